/* File: design/seq_slot_consts.svh */
`ifndef SEQ_SLOT_CONSTS_SVH
`define SEQ_SLOT_CONSTS_SVH
// Printed register indices; byte address is four times the index
`define SLOT_19_IDX       6'h33
`define SLOT_20_IDX       6'h34
`define SLOT_21_IDX       6'h35
`define SLOT_22_IDX       6'h36
// Own control and status registers
`define CTRL_IDX          6'h3c
`define STATUS_IDX        6'h3d
`define FIRST_SLOT_IDX    6'h33
`define SLOT_COUNT        3'h4
// Reset values of the four slots
`define SLOT_19_RESET     16'h6600
`define SLOT_20_RESET     16'h6800
`define SLOT_21_RESET     16'h6a00
`define SLOT_22_RESET     16'h6c00
// Field positions inside a slot word
`define DIR_BIT           15
`define ADDR_HI           14
`define ADDR_LO           9
`define RET_BIT           8
`define CHB_HI            7
`define CHB_LO            4
`define CHA_HI            3
`define CHA_LO            0
// Control register bits
`define CTRL_RUN_BIT      0
`define CTRL_RESTART_BIT  1
`endif

/* File: design/seq_slot_pkg.sv */
package seq_slot_pkg;
  // One stack slot word
  typedef struct packed
  {
    logic       direction;
    logic [5:0] slot_address_field;
    logic       stack_return_select;
    logic [3:0] converter_b_channel_pick;
    logic [3:0] converter_a_channel_pick;
  } slot_word_type;

  // Channel pair handed to the converters
  typedef struct packed
  {
    logic [3:0] chan_b;
    logic [3:0] chan_a;
  } chan_pair_type;

  typedef enum logic [1:0]
  {
    seq_idle,
    seq_wait,
    seq_step
  } seq_state_type;
endpackage

/* File: design/slot_reg.sv */
`timescale 1ns/1ps
`include "seq_slot_consts.svh"
// One stack slot register with its own reset word
module slot_reg #(
  parameter logic [15:0] RESET_WORD = 16'h0000
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        wr_en,
  input  wire logic [15:0]                 wr_data,
  output seq_slot_pkg::slot_word_type      slot_q
);
  seq_slot_pkg::slot_word_type slot_r;

  // Reset to the slot's own word, load on a decoded write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slot_r <= RESET_WORD;
    else if (wr_en)
      slot_r <= wr_data;
  end

  assign slot_q = slot_r;
endmodule

/* File: design/slot_sequencer.sv */
`timescale 1ns/1ps
`include "seq_slot_consts.svh"
// Walks the slots one conversion at a time
module slot_sequencer (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       run,
  input  wire logic                       restart,
  input  wire logic                       conv_done,
  input  wire logic [3:0]                 ret_bits,
  output logic [1:0]                      cur_idx,
  output logic                            active
);
  seq_slot_pkg::seq_state_type state_r;
  logic [1:0]                  idx_r;

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= seq_slot_pkg::seq_idle;
    else if (!run)
      state_r <= seq_slot_pkg::seq_idle;
    else
    begin
      unique case (state_r)
        seq_slot_pkg::seq_idle: state_r <= seq_slot_pkg::seq_wait;
        seq_slot_pkg::seq_wait:
          if (conv_done)
            state_r <= seq_slot_pkg::seq_step;
        seq_slot_pkg::seq_step: state_r <= seq_slot_pkg::seq_wait;
        // Unused fourth code falls back to idle
        default: state_r <= seq_slot_pkg::seq_idle;
      endcase
    end
  end

  // Slot pointer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idx_r <= 2'h0;
    else if (!run || restart)
      idx_r <= 2'h0;
    else if (state_r == seq_slot_pkg::seq_wait && conv_done && ret_bits[idx_r])
      idx_r <= 2'h0;
    else if (state_r == seq_slot_pkg::seq_wait && conv_done)
      idx_r <= idx_r + 2'h1;
  end

  assign cur_idx = idx_r;
  assign active  = (state_r != seq_slot_pkg::seq_idle);
endmodule

/* File: design/seq_stack_slots.sv */
`timescale 1ns/1ps
`include "seq_slot_consts.svh"
// Summary of operation
// - Bit 15 selects read or write
// - Address field resets to own address
// - Return bit zero advances to next slot
// - Return bit one wraps to first slot
// - Bits 7-4 pick converter B channel
// - Bits 3-0 pick converter A channel
// - Slots 19-21 reset to 6600, 6800, 6a00
// - Slot 22 at 0x36, resets 6c00
module seq_stack_slots (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       conv_done,
  output seq_slot_pkg::chan_pair_type     chan_sel,
  output logic                            seq_active
);
  seq_slot_pkg::slot_word_type slot_q [4];
  seq_slot_pkg::chan_pair_type chan_r;
  logic [31:0]                 prdata_r;
  logic [0:0]                  ctrl_r;
  logic [3:0]                  wr_en;
  logic [3:0]                  ret_bits;
  logic [1:0]                  cur_idx;
  logic                        restart_r;
  logic                        wr_acc;
  logic                        rd_acc;
  logic [5:0]                  widx;

  localparam logic [15:0] RESETS [4] = '{`SLOT_19_RESET, `SLOT_20_RESET,
                                         `SLOT_21_RESET, `SLOT_22_RESET};

  // Word index from byte address; returns slot number or 4 if none
  function automatic logic [2:0] slot_of(input logic [5:0] idx);
    if (idx >= `FIRST_SLOT_IDX && idx < `FIRST_SLOT_IDX + 6'(`SLOT_COUNT))
      slot_of = 3'(idx - `FIRST_SLOT_IDX);
    else
      slot_of = 3'h4;
  endfunction

  // Known address decode
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) &&
             (slot_of(a[7:2]) != 3'h4 || a[7:2] == `CTRL_IDX ||
              a[7:2] == `STATUS_IDX);
  endfunction

  assign widx    = paddr[7:2];
  assign wr_acc  = psel && penable && pwrite && mapped(paddr);
  assign rd_acc  = psel && penable && !pwrite && mapped(paddr);
  // Zero wait state slave
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // Slot banks, each with its own reset word
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_slot
      assign wr_en[g] = wr_acc && slot_of(widx) == 3'(g) && (&pstrb[1:0]);
      assign ret_bits[g] = slot_q[g].stack_return_select;
      slot_reg #(
        .RESET_WORD (RESETS[g])
      ) u_slot (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_en[g]),
        .wr_data (pwdata[15:0]),
        .slot_q  (slot_q[g])
      );
    end
  endgenerate

  // Control register: run enable and restart pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= 1'h0;
    else if (wr_acc && widx == `CTRL_IDX && pstrb[0])
      ctrl_r <= pwdata[`CTRL_RUN_BIT];
  end

  // Restart strobe, one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      restart_r <= 1'b0;
    else
      restart_r <= wr_acc && widx == `CTRL_IDX && pstrb[0] &&
                   pwdata[`CTRL_RESTART_BIT];
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (slot_of(widx) != 3'h4)
        prdata_r <= {16'h0000, slot_q[2'(slot_of(widx))][15:0]};
      else if (widx == `CTRL_IDX)
        prdata_r <= {31'h0, ctrl_r[0]};
      else if (widx == `STATUS_IDX)
        prdata_r <= {29'h0, seq_active, cur_idx};
      else
        prdata_r <= 32'h0000_0000;
    end
  end

  assign prdata = rd_acc ? prdata_r : 32'h0000_0000;

  slot_sequencer u_seq (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (ctrl_r[0]),
    .restart   (restart_r),
    .conv_done (conv_done),
    .ret_bits  (ret_bits),
    .cur_idx   (cur_idx),
    .active    (seq_active)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_r <= 8'h00;
    else
      chan_r <= {slot_q[cur_idx].converter_b_channel_pick,
                 slot_q[cur_idx].converter_a_channel_pick};
  end

  assign chan_sel = chan_r;
endmodule

/* File: test/seq_stack_slots_monitor.sv */
`timescale 1ns/1ps
// Port checks of the slot bank
module seq_stack_slots_monitor (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        conv_done,
  input wire seq_slot_pkg::chan_pair_type chan_sel,
  input wire logic                        seq_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd;
  logic map;
  // Access phase and address decode
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign map = paddr inside {8'hcc, 8'hd0, 8'hd4, 8'hd8, 8'hf0, 8'hf4};
  // Full write to the first slot, then a read setup of it
  sequence wr19;
    acc && pwrite && paddr == 8'hcc && pstrb[1:0] == 2'h3;
  endsequence
  sequence rd19;
    psel && !penable && !pwrite && paddr == 8'hcc ##1 acc;
  endsequence
  chk_ready_high:
    assert property (pready) else $error("pready low");
  chk_read_only:
    assert property (!rd |-> prdata == 32'h0) else $error("prdata leak");
  chk_upper_zero:
    assert property (rd |-> prdata[31:16] == 16'h0) else $error("upper");
  chk_bad_addr:
    assert property (acc && !map |-> pslverr) else $error("no pslverr");
  chk_good_addr:
    assert property (acc && map |-> !pslverr) else $error("pslverr");
  chk_err_idle:
    assert property (!acc |-> !pslverr) else $error("stray pslverr");
  chk_slot_keep:
    assert property (wr19 ##1 rd19 |-> prdata[15:0] == $past(pwdata[15:0], 2))
      else $error("slot word lost");
  chk_reset_chan:
    assert property ($rose(presetn) |-> chan_sel == 8'h00)
      else $error("chan_sel reset");
endmodule
bind seq_stack_slots seq_stack_slots_monitor mon (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .conv_done, .chan_sel, .seq_active);

/* File: test/conv_model.sv */
`timescale 1ns/1ps
// Converter stand-in: one done pulse some cycles after each start
module conv_model #(
  parameter int CONV_CYCLES = 3
) (
  input  wire logic pclk,
  input  wire logic start,
  output logic      conv_done = 1'h0
);
  int cnt = 0;
  // One conversion per start, done lasts one cycle
  always @(posedge pclk)
  begin
    conv_done <= (cnt == 1);
    if (start)
      cnt <= CONV_CYCLES;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule

/* File: test/tb_seq_stack_slots.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("Error %s exp %h got %h", n, e, g); \
    end \
  end
module tb_seq_stack_slots;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, conv_done, seq_active, start = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [3:0]  pstrb = 4'hf;
  logic [15:0] rst_v [4] = '{16'h6600, 16'h6800, 16'h6a00, 16'h6c00};
  logic [15:0] prog [4] = '{16'he621, 16'he843, 16'heb65, 16'hec87};
  logic [7:0]  exp_ch [5] = '{8'h21, 8'h43, 8'h65, 8'h21, 8'h43};
  int          fail_count = 0, samples_checked = 0;
  seq_slot_pkg::chan_pair_type chan_sel;
  // Clock
  always #20 pclk = ~pclk;
  seq_stack_slots dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .conv_done, .chan_sel,
    .seq_active);
  conv_model conv (.pclk, .start, .conv_done);
  // APB transfer, left in access phase so another may follow at once
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    err = pslverr;
  endtask
  task idle;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    `CHK("prdata", e, rv)
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge pclk);
    fail_count++;
    wrap_up;
  end
  // Reset values, slot round trips, bad address, then a sequencer run
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
      rd(8'hcc + 8'(4 * i), {16'h0, rst_v[i]});
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'h1, 8'hcc + 8'(4 * i), {16'h0, prog[i]});
      rd(8'hcc + 8'(4 * i), {16'h0, prog[i]});
    end
    rd(8'h40, 32'h0);
    `CHK("pslverr", 1'h1, err)
    // Low byte strobe only: slot word must stay as programmed
    pstrb <= 4'h1;
    xfer(1'h1, 8'hcc, 32'h0);
    pstrb <= 4'hf;
    rd(8'hcc, {16'h0, prog[0]});
    xfer(1'h1, 8'hf0, 32'h1);
    idle;
    foreach (exp_ch[k])
    begin
      repeat (6) @(posedge pclk);
      `CHK("chan_sel", exp_ch[k], chan_sel)
      start <= 1'h1;
      @(posedge pclk);
      start <= 1'h0;
    end
    repeat (6) @(posedge pclk);
    rd(8'hf4, 32'h6);
    rd(8'hf0, 32'h1);
    // Restart pulse sends the pointer back to the first slot
    xfer(1'h1, 8'hf0, 32'h3);
    idle;
    rd(8'hf4, 32'h4);
    // Clearing run stops the sequencer
    xfer(1'h1, 8'hf0, 32'h0);
    idle;
    idle;
    `CHK("seq_active", 1'h0, seq_active)
    wrap_up;
  end
endmodule
